//--- tct_top.sv
// three 16-bit timer/counters behind an AXI4-Lite register slave
// Behaviour
// - units 0 and 1 configured independently
// - bytes cascade to 16 bits, overflow flags
// - run bit starts counting, keeps contents
// - timer counts once per six-period cycle
// - counter counts sampled high-then-low pin
// - edge needs two cycles, max rate/24, /12 in x2 mode
// - unit 0 fields in mode/control nibbles
// - gate off: run bit alone enables
// - unit 0 rollover sets overflow flag
// - unit 2 counts tick or pin when run
// - down enable: direction pin picks direction
// - up overflow sets flag, loads reload
// - down match reload: flag, load ffff
// - extension flag toggles, no interrupt
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module tct_top #(
	parameter int ADDR_W = tct_pkg::ADDR_W // register address width
) (
	input wire logic clk_in, // 100 MHz clock
	input wire logic arst_n_in, // async reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in, // write address
	input wire logic s_axi_awvalid_in, // write address valid
	output logic s_axi_awready_out, // write address ready
	input wire logic [31:0] s_axi_wdata_in, // write data
	input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
	input wire logic s_axi_wvalid_in, // write data valid
	output logic s_axi_wready_out, // write data ready
	output logic [1:0] s_axi_bresp_out, // write response
	output logic s_axi_bvalid_out, // write response valid
	input wire logic s_axi_bready_in, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr_in, // read address
	input wire logic s_axi_arvalid_in, // read address valid
	output logic s_axi_arready_out, // read address ready
	output logic [31:0] s_axi_rdata_out, // read data
	output logic [1:0] s_axi_rresp_out, // read response
	output logic s_axi_rvalid_out, // read data valid
	input wire logic s_axi_rready_in, // read data ready
	input wire logic [1:0] count_pin_in, // external count pins, units 0 and 1
	input wire logic [1:0] ext_irq_pin_in, // external interrupt / gate pins
	input wire logic unit2_count_pin_in, // unit 2 external count pin
	input wire logic unit2_direction_pin_in, // unit 2 direction pin
	output logic irq_out // level interrupt, active high
);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	////////////////////////////////////////////////////////////////////////////
	// register bus slave

	logic awready_q;
	logic aw_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic wready_q;
	logic w_hold_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_wr;
	logic wr_lo;
	logic wr_hi;
	logic wr_mapped;
	logic [31:0] rd_d;
	logic rd_mapped;

	assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_lo = do_wr && wstrb_q[0];
	assign wr_hi = do_wr && wstrb_q[1];

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			awready_q <= 1'b1;
			aw_hold_q <= 1'b0;
			awaddr_q <= '0;
		end
		else if (do_wr)
		begin
			awready_q <= 1'b1;
			aw_hold_q <= 1'b0;
		end
		else if (s_axi_awvalid_in && awready_q)
		begin
			awready_q <= 1'b0;
			aw_hold_q <= 1'b1;
			awaddr_q <= s_axi_awaddr_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wready_q <= 1'b1;
			w_hold_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else if (do_wr)
		begin
			wready_q <= 1'b1;
			w_hold_q <= 1'b0;
		end
		else if (s_axi_wvalid_in && wready_q)
		begin
			wready_q <= 1'b0;
			w_hold_q <= 1'b1;
			wdata_q <= s_axi_wdata_in;
			wstrb_q <= s_axi_wstrb_in;
		end
	end

	always_comb
	begin
		case (awaddr_q)
			tct_pkg::OFF_CTRL, tct_pkg::OFF_MODE, tct_pkg::OFF_CNT0, tct_pkg::OFF_CNT1,
			tct_pkg::OFF_STAT, tct_pkg::OFF_MASK, tct_pkg::OFF_U2CTRL, tct_pkg::OFF_U2MODE,
			tct_pkg::OFF_CNT2, tct_pkg::OFF_RELOAD, tct_pkg::OFF_CFG: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= tct_pkg::RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? tct_pkg::RESP_OKAY : tct_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready_in)
		begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= tct_pkg::RESP_OKAY;
		end
		else if (rvalid_q)
		begin
			if (s_axi_rready_in)
			begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
		else if (s_axi_arvalid_in && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_mapped ? tct_pkg::RESP_OKAY : tct_pkg::RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	logic [1:0] run_q;
	logic [1:0] itype_q;
	tct_pkg::tct_unit_cfg_t cfg_q [2];
	tct_pkg::tct_u2_cfg_t u2_q;
	logic x2_q;
	logic [15:0] reload_q;
	logic [tct_pkg::ST_W-1:0] mask_q;

	function automatic logic wr_at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		wr_at = wr_lo && (a == off);
	endfunction : wr_at

	// mode changes while running are the software's problem, not guarded here
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			run_q <= '0;
			itype_q <= '0;
			cfg_q[0] <= tct_pkg::tct_unit_cfg_t'(tct_pkg::MODE_RST[3:0]);
			cfg_q[1] <= tct_pkg::tct_unit_cfg_t'(tct_pkg::MODE_RST[7:4]);
			u2_q <= '0;
			x2_q <= 1'b0;
			mask_q <= '0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (wr_at(awaddr_q, tct_pkg::OFF_CTRL))
				begin
					run_q[i] <= wdata_q[tct_pkg::CTRL_RUN0 + i * tct_pkg::CTRL_UNIT1_SHIFT];
					itype_q[i] <= wdata_q[tct_pkg::CTRL_TYPE0 + i * tct_pkg::CTRL_UNIT1_SHIFT];
				end
				if (wr_at(awaddr_q, tct_pkg::OFF_MODE))
				begin
					cfg_q[i] <= wdata_q[i * tct_pkg::MODE_NIBBLE_W +: tct_pkg::MODE_NIBBLE_W];
				end
			end
			if (wr_at(awaddr_q, tct_pkg::OFF_U2CTRL))
			begin
				u2_q.run <= wdata_q[tct_pkg::U2_RUN];
				u2_q.csel <= wdata_q[tct_pkg::U2_SEL];
			end
			if (wr_at(awaddr_q, tct_pkg::OFF_U2MODE))
			begin
				u2_q.down_count_enable <= wdata_q[tct_pkg::U2_DOWN_COUNT_ENABLE];
			end
			if (wr_at(awaddr_q, tct_pkg::OFF_CFG))
			begin
				x2_q <= wdata_q[tct_pkg::CFG_X2];
			end
			if (wr_at(awaddr_q, tct_pkg::OFF_MASK))
			begin
				mask_q <= wdata_q[tct_pkg::ST_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			reload_q <= tct_pkg::CNT_RST;
		end
		else if (awaddr_q == tct_pkg::OFF_RELOAD)
		begin
			if (wr_lo)
			begin
				reload_q[7:0] <= wdata_q[7:0];
			end
			if (wr_hi)
			begin
				reload_q[15:8] <= wdata_q[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// peripheral cycle prescaler and pin samplers

	logic [tct_pkg::PRE_W-1:0] pre_q;
	logic [tct_pkg::PRE_W-1:0] pre_lim;
	logic tick_q;
	logic [1:0] gate_lvl;
	logic [1:0] cnt_fall;
	logic [1:0] irq_fall;
	logic u2_fall;
	logic dir_lvl;

	// standard mode doubles the oscillator periods per peripheral clock
	assign pre_lim = x2_q ? tct_pkg::PRE_W'(tct_pkg::PER_CLKS_PER_CYCLE - 1)
		: tct_pkg::PRE_W'(tct_pkg::PER_CLKS_PER_CYCLE * tct_pkg::STD_CLK_DIV - 1);

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pre_q <= '0;
			tick_q <= 1'b0;
		end
		else if (pre_q >= pre_lim)
		begin
			pre_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			pre_q <= pre_q + tct_pkg::PRE_W'(1);
			tick_q <= 1'b0;
		end
	end

	AST_TICK_SPACING: assert property (tick_q |=> !tick_q [*5])
		else $error("peripheral tick closer than six clocks");

	for (genvar g = 0; g < 2; g++)
	begin : g_unit_pins
		tct_pin_sample u_cnt (
			.clk_in(clk_in),
			.arst_n_in(arst_n_in),
			.pin_in(count_pin_in[g]),
			.tick_in(tick_q),
			.level_out(),
			.fall_out(cnt_fall[g])
		);
		tct_pin_sample u_irq (
			.clk_in(clk_in),
			.arst_n_in(arst_n_in),
			.pin_in(ext_irq_pin_in[g]),
			.tick_in(tick_q),
			.level_out(gate_lvl[g]),
			.fall_out(irq_fall[g])
		);
	end

	tct_pin_sample u_u2_cnt (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.pin_in(unit2_count_pin_in),
		.tick_in(tick_q),
		.level_out(),
		.fall_out(u2_fall)
	);

	tct_pin_sample u_u2_dir (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.pin_in(unit2_direction_pin_in),
		.tick_in(tick_q),
		.level_out(dir_lvl),
		.fall_out()
	);

	////////////////////////////////////////////////////////////////////////////
	// units 0 and 1

	logic [15:0] cnt_q [2];
	logic [15:0] cnt_d [2];
	logic [1:0] inc;
	logic [1:0] ovf;
	logic [1:0] wr_cnt;

	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			wr_cnt[i] = awaddr_q == (i == 0 ? tct_pkg::OFF_CNT0 : tct_pkg::OFF_CNT1);
			inc[i] = run_q[i] && (!cfg_q[i].gate || gate_lvl[i])
				&& (cfg_q[i].csel ? cnt_fall[i] : tick_q);
			ovf[i] = inc[i] && (cnt_q[i] == tct_pkg::CNT_MAX);
			cnt_d[i] = inc[i] ? cnt_q[i] + 16'h0001 : cnt_q[i];
			if (wr_lo && wr_cnt[i])
			begin
				cnt_d[i][7:0] = wdata_q[7:0];
			end
			if (wr_hi && wr_cnt[i])
			begin
				cnt_d[i][15:8] = wdata_q[15:8];
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cnt_q[0] <= tct_pkg::CNT_RST;
			cnt_q[1] <= tct_pkg::CNT_RST;
		end
		else
		begin
			cnt_q[0] <= cnt_d[0];
			cnt_q[1] <= cnt_d[1];
		end
	end

	AST_U0_STOPPED_HOLDS: assert property (!run_q[0] && !(do_wr && wr_cnt[0])
		|=> $stable(cnt_q[0]))
		else $error("unit 0 count moved while stopped");

	AST_U0_GATE_HOLDS: assert property (cfg_q[0].gate && !gate_lvl[0]
		&& !(do_wr && wr_cnt[0]) |=> $stable(cnt_q[0]))
		else $error("gated unit 0 counted with gate pin low");

	AST_U0_TIMER_STEP: assert property (run_q[0] && !cfg_q[0].gate && !cfg_q[0].csel
		&& tick_q && !(do_wr && wr_cnt[0]) |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
		else $error("unit 0 missed a timer tick");

	AST_U0_COUNTER_EDGE: assert property (cfg_q[0].csel && !cnt_fall[0]
		&& !(do_wr && wr_cnt[0]) |=> $stable(cnt_q[0]))
		else $error("unit 0 counted without a pin edge");

	////////////////////////////////////////////////////////////////////////////
	// unit 2, auto-reload up or down

	logic [15:0] cnt2_q;
	logic [15:0] cnt2_d;
	logic ext_q;
	logic inc2;
	logic up2;
	logic ev2;
	logic wr_cnt2;
	logic [tct_pkg::ST_W-1:0] st_q;

	assign wr_cnt2 = awaddr_q == tct_pkg::OFF_CNT2;
	assign inc2 = u2_q.run && (u2_q.csel ? u2_fall : tick_q);
	assign up2 = !u2_q.down_count_enable || dir_lvl;

	always_comb
	begin
		ev2 = 1'b0;
		cnt2_d = cnt2_q;
		if (inc2 && up2)
		begin
			if (cnt2_q == tct_pkg::CNT_MAX)
			begin
				ev2 = 1'b1;
				cnt2_d = reload_q;
			end
			else
			begin
				cnt2_d = cnt2_q + 16'h0001;
			end
		end
		else if (inc2)
		begin
			if (cnt2_q == reload_q)
			begin
				ev2 = 1'b1;
				cnt2_d = tct_pkg::CNT_MAX;
			end
			else
			begin
				cnt2_d = cnt2_q - 16'h0001;
			end
		end
		if (wr_lo && wr_cnt2)
		begin
			cnt2_d[7:0] = wdata_q[7:0];
		end
		if (wr_hi && wr_cnt2)
		begin
			cnt2_d[15:8] = wdata_q[15:8];
		end
	end

	// the extension bit only toggles; it is kept out of the interrupt status
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cnt2_q <= tct_pkg::CNT_RST;
			ext_q <= 1'b0;
		end
		else
		begin
			cnt2_q <= cnt2_d;
			ext_q <= ext_q ^ ev2;
		end
	end

	AST_U2_UP_RELOAD: assert property (inc2 && up2 && cnt2_q == tct_pkg::CNT_MAX
		&& !(do_wr && wr_cnt2) |=> cnt2_q == $past(reload_q) && st_q[tct_pkg::ST_OVF2])
		else $error("unit 2 overflow did not reload and flag");

	AST_U2_DOWN_UNDERFLOW: assert property (inc2 && !up2 && cnt2_q == reload_q
		&& !(do_wr && wr_cnt2) |=> cnt2_q == tct_pkg::CNT_MAX && st_q[tct_pkg::ST_OVF2])
		else $error("unit 2 underflow did not load ffff and flag");

	AST_U2_EXT_TOGGLE: assert property (ev2 |=> ext_q != $past(ext_q))
		else $error("extension bit did not toggle");

	AST_U2_UP_ONLY: assert property (!u2_q.down_count_enable && inc2 && cnt2_q != tct_pkg::CNT_MAX
		&& !(do_wr && wr_cnt2) |=> cnt2_q == $past(cnt2_q) + 16'h0001)
		else $error("unit 2 did not count up with down count disabled");

	////////////////////////////////////////////////////////////////////////////
	// sticky status, mask and interrupt

	logic [tct_pkg::ST_W-1:0] st_set;
	logic [tct_pkg::ST_W-1:0] st_clr;
	logic irq_q;

	always_comb
	begin
		st_set = '0;
		st_set[tct_pkg::ST_OVF0] = ovf[0];
		st_set[tct_pkg::ST_OVF1] = ovf[1];
		st_set[tct_pkg::ST_OVF2] = ev2;
		for (int i = 0; i < 2; i++)
		begin
			st_set[tct_pkg::ST_IRQ0 + i] = itype_q[i] ? irq_fall[i] : (tick_q && !gate_lvl[i]);
		end
		st_clr = wr_at(awaddr_q, tct_pkg::OFF_STAT) ? wdata_q[tct_pkg::ST_W-1:0] : '0;
	end

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			st_q <= (st_q & ~st_clr) | st_set;
			irq_q <= |(st_q & mask_q);
		end
	end

	AST_U0_ROLLOVER_FLAG: assert property (ovf[0] && !(do_wr && wr_cnt[0])
		|=> cnt_q[0] == tct_pkg::CNT_RST && st_q[tct_pkg::ST_OVF0])
		else $error("unit 0 rollover did not wrap and flag");

	AST_IRQ_FOLLOWS: assert property (|(st_q & mask_q) |=> irq_q)
		else $error("interrupt not raised for unmasked status");

	////////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb
	begin
		rd_d = '0;
		rd_mapped = 1'b1;
		case (s_axi_araddr_in)
			tct_pkg::OFF_CTRL:
			begin
				for (int i = 0; i < 2; i++)
				begin
					rd_d[tct_pkg::CTRL_OVF0 + i * tct_pkg::CTRL_UNIT1_SHIFT] = st_q[tct_pkg::ST_OVF0 + i];
					rd_d[tct_pkg::CTRL_RUN0 + i * tct_pkg::CTRL_UNIT1_SHIFT] = run_q[i];
					rd_d[tct_pkg::CTRL_IRQF0 + i * tct_pkg::CTRL_UNIT1_SHIFT] = st_q[tct_pkg::ST_IRQ0 + i];
					rd_d[tct_pkg::CTRL_TYPE0 + i * tct_pkg::CTRL_UNIT1_SHIFT] = itype_q[i];
				end
			end
			tct_pkg::OFF_MODE: rd_d[7:0] = {cfg_q[1], cfg_q[0]};
			tct_pkg::OFF_CNT0: rd_d[15:0] = cnt_q[0];
			tct_pkg::OFF_CNT1: rd_d[15:0] = cnt_q[1];
			tct_pkg::OFF_STAT: rd_d[tct_pkg::ST_W-1:0] = st_q;
			tct_pkg::OFF_MASK: rd_d[tct_pkg::ST_W-1:0] = mask_q;
			tct_pkg::OFF_U2CTRL:
			begin
				rd_d[tct_pkg::U2_RUN] = u2_q.run;
				rd_d[tct_pkg::U2_SEL] = u2_q.csel;
				rd_d[tct_pkg::U2_EXT] = ext_q;
				rd_d[tct_pkg::U2_OVF] = st_q[tct_pkg::ST_OVF2];
			end
			tct_pkg::OFF_U2MODE: rd_d[tct_pkg::U2_DOWN_COUNT_ENABLE] = u2_q.down_count_enable;
			tct_pkg::OFF_CNT2: rd_d[15:0] = cnt2_q;
			tct_pkg::OFF_RELOAD: rd_d[15:0] = reload_q;
			tct_pkg::OFF_CFG: rd_d[tct_pkg::CFG_X2] = x2_q;
			default: rd_mapped = 1'b0;
		endcase
	end

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;
	assign irq_out = irq_q;

endmodule : tct_top

//--- tct_pkg.sv
// constants, register map and carrier types of the three-unit timer/counter block
package tct_pkg;

	localparam int unsigned ADDR_W = 6;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_MODE = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_CNT0 = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_CNT1 = 6'h0c;
	localparam logic [ADDR_W-1:0] OFF_STAT = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_MASK = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_U2CTRL = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_U2MODE = 6'h1c;
	localparam logic [ADDR_W-1:0] OFF_CNT2 = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_RELOAD = 6'h24;
	localparam logic [ADDR_W-1:0] OFF_CFG = 6'h28;

	// timer_control_register fields, unit 1 sits two bits above unit 0
	localparam int CTRL_OVF0 = 0;
	localparam int CTRL_RUN0 = 1;
	localparam int CTRL_IRQF0 = 4;
	localparam int CTRL_TYPE0 = 5;
	localparam int CTRL_UNIT1_SHIFT = 2;

	// timer_mode_register: one nibble per unit
	localparam int MODE_NIBBLE_W = 4;

	// status and mask layout
	localparam int ST_OVF0 = 0;
	localparam int ST_OVF1 = 1;
	localparam int ST_OVF2 = 2;
	localparam int ST_IRQ0 = 3;
	localparam int ST_IRQ1 = 4;
	localparam int ST_W = 5;

	// unit2_control_register, unit2_mode_register, config fields
	localparam int U2_RUN = 0;
	localparam int U2_SEL = 1;
	localparam int U2_EXT = 2;
	localparam int U2_OVF = 3;
	localparam int U2_DOWN_COUNT_ENABLE = 0;
	localparam int CFG_X2 = 0;

	// timing: peripheral clock periods per peripheral cycle, oscillator per peripheral clock
	localparam int PER_CLKS_PER_CYCLE = 6;
	localparam int STD_CLK_DIV = 2;
	localparam int PRE_W = 4;

	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [7:0] MODE_RST = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic gate;
		logic csel;
		logic [1:0] mode;
	} tct_unit_cfg_t;

	typedef struct packed {
		logic run;
		logic csel;
		logic down_count_enable;
	} tct_u2_cfg_t;

endpackage : tct_pkg

//--- tct_pin_sample.sv
// two-flop synchroniser and per-peripheral-cycle falling-edge sampler for one pin
`timescale 1ns/1ps
module tct_pin_sample (
	input wire logic clk_in, // block clock
	input wire logic arst_n_in, // async reset, active low
	input wire logic pin_in, // raw external pin
	input wire logic tick_in, // one pulse per peripheral cycle
	output logic level_out, // level sampled at last tick
	output logic fall_out // pulse: high sample then low sample
);

	logic sync1_q;
	logic sync2_q;
	logic samp_q;
	logic fall_q;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// pins idle high, so the sample starts high to avoid a false edge
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			samp_q <= 1'b1;
			fall_q <= 1'b0;
		end
		else if (tick_in)
		begin
			samp_q <= sync2_q;
			fall_q <= samp_q & ~sync2_q;
		end
		else
		begin
			fall_q <= 1'b0;
		end
	end

	assign level_out = samp_q;
	assign fall_out = fall_q;

	AST_FALL_NEEDS_TWO_SAMPLES: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		fall_q |-> !samp_q && $past(samp_q, 2))
		else $error("edge reported without high then low sample");

endmodule : tct_pin_sample

//--- tct_pin_model.sv
// far-side pin model: count, gate and direction pins
`timescale 1ns/1ps
module tct_pin_model (
	input wire logic clk_in, // block clock
	output logic [1:0] count_pin_out, // unit 0/1 count pins
	output logic [1:0] ext_irq_pin_out, // gate pins
	output logic unit2_count_pin_out, // unit 2 count pin
	output logic unit2_direction_pin_out // high counts up
);
	initial
	begin
		count_pin_out = 2'h3;
		ext_irq_pin_out = 2'h3;
		unit2_count_pin_out = 1'h1;
		unit2_direction_pin_out = 1'h1;
	end
	////////////////////////////////////////////////////////////////
	// hold varies so the sampler sees both prompt and slow sources
	task automatic burst(input int u, input int n, input int hold);
		repeat (n)
		begin
			repeat (hold) @(posedge clk_in);
			count_pin_out[u] <= 1'b0;
			repeat (hold) @(posedge clk_in);
			count_pin_out[u] <= 1'b1;
		end
	endtask : burst
	task automatic set_gate(input int u, input logic v);
		ext_irq_pin_out[u] <= v;
	endtask : set_gate
	task automatic set_dir(input logic v);
		unit2_direction_pin_out <= v;
	endtask : set_dir
endmodule : tct_pin_model

//--- tct_top_test.sv
// self-checking bench of the three-unit timer/counter block
`timescale 1ns/1ps
module tct_top_test;
	typedef struct packed {
		logic [31:0] lo;
		logic [31:0] hi;
		logic [1:0] resp;
	} tct_note_t;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic bready = 1'b1, rready = 1'b1;
	logic [3:0] wstrb = 4'h3;
	logic awready, wready, bvalid, arready, rvalid, irq, t2pin, dpin;
	logic [1:0] bresp, rresp, cpin, gpin;
	logic [31:0] rdata;
	logic [15:0] q, r, p0, p1;
	tct_note_t rq[$];
	logic [1:0] bq[$];
	int n_errors = 0, checks = 0, seed = 23293, n, i;

	tct_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .count_pin_in(cpin),
		.ext_irq_pin_in(gpin), .unit2_count_pin_in(t2pin),
		.unit2_direction_pin_in(dpin), .irq_out(irq));
	tct_pin_model pm (.clk_in(clk_in), .count_pin_out(cpin), .ext_irq_pin_out(gpin),
		.unit2_count_pin_out(t2pin), .unit2_direction_pin_out(dpin));

	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic bad(input string what, input logic [31:0] e, input logic [31:0] s);
		n_errors++;
		$display("[ERR] %s expected %h seen %h", what, e, s);
	endtask : bad
	task automatic cmp_read(input tct_note_t nt, input logic [31:0] d, input logic [1:0] rs);
		checks++;
		if (((d >= nt.lo) && (d <= nt.hi)) !== 1'b1 || rs !== nt.resp)
			bad("read", nt.lo, d);
	endtask : cmp_read
	task automatic cmp_bresp(input logic [1:0] e, input logic [1:0] s);
		checks++;
		if (s !== e)
			bad("bresp", 32'(e), 32'(s));
	endtask : cmp_bresp
	// waits a bounded time for the interrupt line to reach e
	task automatic cmp_irq(input logic e, input int lim);
		int k;
		checks++;
		for (k = 0; k < lim && irq !== e; k++)
			@(posedge clk_in);
		if (irq !== e)
			bad("irq", 32'(e), 32'(irq));
	endtask : cmp_irq
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		int k;
		bq.push_back(e);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; k < 64; k++)
		begin
			@(posedge clk_in);
			if (bvalid) break;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		if (k == 64)
		begin
			bad("bvalid", 1, 0);
			tally_and_finish();
		end
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] lo, input logic [31:0] hi,
		input logic [1:0] e = 2'h0);
		int k;
		rq.push_back(tct_note_t'{lo, hi, e});
		araddr <= a;
		arvalid <= 1'b1;
		for (k = 0; k < 64; k++)
		begin
			@(posedge clk_in);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (k == 64)
		begin
			bad("rvalid", 1, 0);
			tally_and_finish();
		end
	endtask : rd
	// monitor: oldest note against each answer
	always @(posedge clk_in)
	begin
		if (rvalid && rready && rq.size() > 0) cmp_read(rq.pop_front(), rdata, rresp);
		if (bvalid && bready && bq.size() > 0) cmp_bresp(bq.pop_front(), bresp);
	end
	////////////////////////////////////////////////////////////////
	// unit 0 runs a fixed window; the count grows by lo..hi from a random preset
	task automatic timed(input logic [7:0] m, input logic g, input logic x2, input int lo,
		input int hi);
		q = 16'($random(seed)) & 16'h7fff;
		pm.set_gate(0, g);
		repeat (24) @(posedge clk_in);
		wr(tct_pkg::OFF_CFG, 32'(x2));
		wr(tct_pkg::OFF_MODE, 32'(m));
		wr(tct_pkg::OFF_CNT0, 32'(q));
		wr(tct_pkg::OFF_CTRL, 32'h2);
		repeat (120) @(posedge clk_in);
		wr(tct_pkg::OFF_CTRL, 32'h0);
		rd(tct_pkg::OFF_CNT0, q + lo, q + hi);
	endtask : timed

	initial
	begin
		repeat (16) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(tct_pkg::OFF_CNT2, 0, 0);
		wr(tct_pkg::OFF_CTRL, 32'h23);
		rd(tct_pkg::OFF_CTRL, 32'h22, 32'h22);
		wr(tct_pkg::OFF_CTRL, 32'h0);
		wr(6'h3c, 32'h1, tct_pkg::RESP_SLVERR);
		rd(6'h2c, 0, 0, tct_pkg::RESP_SLVERR);
		wr(tct_pkg::OFF_RELOAD, 32'h1234);
		wstrb <= 4'h1;
		wr(tct_pkg::OFF_RELOAD, 32'h00ff);
		wstrb <= 4'h3;
		rd(tct_pkg::OFF_RELOAD, 32'h12ff, 32'h12ff);
		$display("test registers done");
		timed(8'h00, 1'b1, 1'b0, 9, 11);
		timed(8'h00, 1'b1, 1'b1, 19, 21);
		timed(8'h08, 1'b0, 1'b0, 0, 0);
		timed(8'h08, 1'b1, 1'b0, 9, 11);
		timed(8'h00, 1'b0, 1'b0, 9, 11);
		$display("test timer done");
		p0 = 16'($random(seed)) & 16'h7fff;
		p1 = 16'($random(seed)) & 16'h7fff;
		n = 3 + ($random(seed) & 3);
		pm.set_gate(0, 1'b1);
		wr(tct_pkg::OFF_MODE, 32'h40);
		wr(tct_pkg::OFF_CNT0, 32'(p0));
		wr(tct_pkg::OFF_CNT1, 32'(p1));
		wr(tct_pkg::OFF_CTRL, 32'h0a);
		pm.burst(1, n, 12 + ($random(seed) & 7));
		repeat (40) @(posedge clk_in);
		wr(tct_pkg::OFF_CTRL, 32'h0);
		rd(tct_pkg::OFF_CNT1, p1 + n, p1 + n);
		rd(tct_pkg::OFF_CNT0, p0 + 1, p0 + 16'h1000);
		$display("test counter done");
		wr(tct_pkg::OFF_STAT, 32'h1f);
		wr(tct_pkg::OFF_MASK, 32'h0);
		wr(tct_pkg::OFF_MODE, 32'h0);
		wr(tct_pkg::OFF_CNT0, 32'hffff);
		wr(tct_pkg::OFF_CTRL, 32'h2);
		repeat (30) @(posedge clk_in);
		wr(tct_pkg::OFF_CTRL, 32'h0);
		cmp_irq(1'b0, 1);
		rd(tct_pkg::OFF_STAT, 1, 1);
		rd(tct_pkg::OFF_CNT0, 0, 2);
		wr(tct_pkg::OFF_MASK, 32'h1);
		cmp_irq(1'b1, 8);
		wr(tct_pkg::OFF_STAT, 32'h1);
		cmp_irq(1'b0, 8);
		// edge type: one flag per falling edge, not re-set while the pin stays low
		wr(tct_pkg::OFF_CTRL, 32'h20);
		pm.set_gate(0, 1'b0);
		repeat (40) @(posedge clk_in);
		rd(tct_pkg::OFF_STAT, 32'h8, 32'h8);
		wr(tct_pkg::OFF_STAT, 32'h8);
		repeat (30) @(posedge clk_in);
		rd(tct_pkg::OFF_STAT, 0, 0);
		pm.set_gate(0, 1'b1);
		$display("test overflow done");
		// cases: up with down enable, down, up with down enable off and pin low
		for (i = 0; i < 3; i++)
		begin
			r = (16'($random(seed)) & 16'h7fff) | 16'h0100;
			pm.set_dir(i == 0);
			wr(tct_pkg::OFF_STAT, 32'h1f);
			wr(tct_pkg::OFF_MASK, 32'h4);
			wr(tct_pkg::OFF_U2MODE, 32'(i < 2));
			wr(tct_pkg::OFF_RELOAD, 32'(r));
			wr(tct_pkg::OFF_CNT2, (i != 1) ? 32'hfffe : 32'(r + 1));
			wr(tct_pkg::OFF_U2CTRL, 32'h1);
			cmp_irq(1'b1, 60);
			wr(tct_pkg::OFF_U2CTRL, 32'h0);
			q = (i != 1) ? r : 16'hffff;
			rd(tct_pkg::OFF_CNT2, q, q);
			rd(tct_pkg::OFF_U2CTRL, 8 + 4 * (i != 1), 8 + 4 * (i != 1));
		end
		$display("test reload done");
		tally_and_finish();
	end
endmodule : tct_top_test
